/* sim/deep_sleep_port_clock_gate_tb.sv */
// Self-checking bench for the port clock gate against a register model.
// Assumes the partner model drives power mode and port accesses.
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
    $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module deep_sleep_port_clock_gate_tb;
    localparam logic [11:0] DEEP = port_gate_pkg::DEEP_SLEEP_PORT_CLOCK_ENABLE_OFF;
    localparam logic [1:0] OK_R = port_gate_pkg::RESP_OKAY;
    localparam logic [1:0] ERR_R = port_gate_pkg::RESP_SLVERR;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic clk_en = 1'h1;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, run_cfg, run_en, slp_en, dsl_en, last_rd;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] port_clock_on, port_disable;
    port_gate_pkg::power_mode_type power_mode;
    port_gate_pkg::port_access_type port_access;
    port_gate_pkg::port_answer_type port_answer, ans;
    int err_count = 0;
    int checks = 0;

    always #2.5 aclk = ~aclk;

    port_clock_gate dut (.aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .power_mode, .port_access, .port_answer, .port_clock_on,
        .port_disable, .irq);
    port_partner partner (.aclk, .port_answer, .power_mode, .port_access);

    // ==========================================================
    // Bus tasks
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw;
        logic w;
        aw = 1'h0;
        w = 1'h0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (!(aw && w)) begin
            @(posedge aclk);
            if (s_axi_awready) aw = 1'h1;
            if (s_axi_wready) w = 1'h1;
            if (aw) s_axi_awvalid <= 1'h0;
            if (w) s_axi_wvalid <= 1'h0;
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        `CHK("bresp", er, s_axi_bresp)
        @(posedge aclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        last_rd = s_axi_rdata;
        `CHK("rdata", ed, s_axi_rdata)
        `CHK("rresp", er, s_axi_rresp)
        @(posedge aclk);
    endtask

    // ==========================================================
    // Model and checks
    function automatic logic [7:0] gate_exp(input port_gate_pkg::power_mode_type m);
        if (!run_cfg[port_gate_pkg::AUTO_SLEEP_GATE_SELECT_BIT] || m == port_gate_pkg::MODE_RUN)
            return run_en[7:0];
        return (m == port_gate_pkg::MODE_SLEEP) ? slp_en[7:0] : dsl_en[7:0];
    endfunction
    task automatic check_mode(input port_gate_pkg::power_mode_type m);
        logic [7:0] e;
        e = gate_exp(m);
        partner.set_mode(m);
        repeat (3) @(posedge aclk);
        `CHK("port_clock_on", e, port_clock_on)
        for (int p = 0; p < 8; p++) begin
            partner.access(p[0], p[2:0], ans);
            `CHK("fault", ~e[p], ans.fault)
            `CHK("resp", e[p] ? OK_R : ERR_R, ans.resp)
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        #50000;
        err_count++;
        stop_test;
    end

    initial begin
        void'($urandom(27824));
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (2) @(posedge aclk);
        `CHK("port_clock_on", 8'h00, port_clock_on)
        rd(DEEP, 32'h0, OK_R);
        rd(12'h3fc, 32'h0, ERR_R);
        wr(12'h3fc, 32'hffff_ffff, ERR_R);
        $display("test reset done");
        // Auto gating on for two rounds, then off to check the run set keeps ruling.
        for (int i = 0; i < 4; i++) begin
            run_cfg = (i < 2) ? (32'h1 << port_gate_pkg::AUTO_SLEEP_GATE_SELECT_BIT) : 32'h0;
            run_en = $urandom;
            slp_en = $urandom;
            dsl_en = $urandom;
            wr(port_gate_pkg::RUN_CLOCK_CONFIG_OFF, run_cfg, OK_R);
            wr(port_gate_pkg::RUN_PORT_CLOCK_ENABLE_OFF, run_en, OK_R);
            wr(port_gate_pkg::SLEEP_PORT_CLOCK_ENABLE_OFF, slp_en, OK_R);
            wr(DEEP, dsl_en, OK_R);
            rd(DEEP, {24'h0, dsl_en[7:0]}, OK_R);
            check_mode(port_gate_pkg::MODE_RUN);
            check_mode(port_gate_pkg::MODE_SLEEP);
            check_mode(port_gate_pkg::MODE_DEEP_SLEEP);
        end
        $display("test gating done");
        wr(DEEP, last_rd | 32'h80, OK_R);
        rd(DEEP, {24'h0, dsl_en[7:0] | 8'h80}, OK_R);
        $display("test rmw done");
        wr(port_gate_pkg::RUN_PORT_CLOCK_ENABLE_OFF, 32'h0, OK_R);
        wr(port_gate_pkg::IRQ_STATUS_OFF, 32'h3, OK_R);
        partner.access(1'h1, 3'h0, ans);
        repeat (2) @(posedge aclk);
        `CHK("irq masked", 1'h0, irq)
        wr(port_gate_pkg::IRQ_MASK_OFF, 32'h1, OK_R);
        `CHK("irq raised", 1'h1, irq)
        rd(port_gate_pkg::IRQ_STATUS_OFF, 32'h1, OK_R);
        wr(port_gate_pkg::IRQ_STATUS_OFF, 32'h1, OK_R);
        `CHK("irq cleared", 1'h0, irq)
        $display("test irq done");
        // Port A stays gated; a frozen block must neither answer nor log the access.
        wr(port_gate_pkg::RUN_PORT_CLOCK_ENABLE_OFF, 32'h5a, OK_R);
        clk_en <= 1'h0;
        partner.set_mode(port_gate_pkg::MODE_RUN);
        @(posedge aclk);
        `CHK("arready", 1'h0, s_axi_arready)
        partner.access(1'h0, 3'h0, ans);
        `CHK("frozen fault", 1'h0, ans.fault)
        `CHK("port_clock_on", 8'h5a, port_clock_on)
        clk_en <= 1'h1;
        repeat (2) @(posedge aclk);
        rd(port_gate_pkg::POWER_STATE_OFF, {14'h0, port_gate_pkg::MODE_RUN, 16'h005a},
           OK_R);
        rd(port_gate_pkg::IRQ_STATUS_OFF, 32'h1 << port_gate_pkg::IRQ_MODE_BIT, OK_R);
        $display("test clock enable done");
        aresetn <= 1'h0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (2) @(posedge aclk);
        `CHK("port_clock_on", 8'h00, port_clock_on)
        rd(DEEP, 32'h0, OK_R);
        $display("test second reset done");
        stop_test;
    end
endmodule

/* sim/port_clock_gate_props.sv */
// Concurrent checks on the top-level ports of the port clock gate.
// Assumes it is bound to every port_clock_gate instance.
`timescale 1ns/10ps
module port_clock_gate_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire port_gate_pkg::power_mode_type power_mode,
    input wire port_gate_pkg::port_access_type port_access,
    input wire port_gate_pkg::port_answer_type port_answer,
    input wire logic [7:0] port_clock_on,
    input wire logic [7:0] port_disable
);
    // ==========================================================
    // Assertions
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_disable_inverse: assert property (port_disable == ~port_clock_on)
        else $error("port_disable differs from inverse of port_clock_on");
    a_gated_fault: assert property (clk_en && port_access.valid &&
        !port_clock_on[port_access.port] |=> port_answer.fault &&
        port_answer.resp == port_gate_pkg::RESP_SLVERR) else $error("gated access not faulted");
    a_clocked_okay: assert property (clk_en && port_access.valid &&
        port_clock_on[port_access.port] |=> !port_answer.fault &&
        port_answer.resp == port_gate_pkg::RESP_OKAY) else $error("clocked access faulted");
    a_reset_unclocked: assert property ($rose(aresetn) |->
        port_clock_on == 8'h00 && port_disable == 8'hff) else $error("ports clocked after reset");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
    a_read_latency: assert property (clk_en && s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid) else $error("read answer late");
    a_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_stall_ready: assert property (!clk_en |-> !s_axi_awready && !s_axi_wready
        && !s_axi_arready) else $error("handshake ready while clock enable low");
    c_stall: cover property (!clk_en && port_access.valid);
    c_fault: cover property (port_answer.fault);
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_deep_on: cover property (power_mode == port_gate_pkg::MODE_DEEP_SLEEP && port_clock_on != 8'h00);
endmodule
bind port_clock_gate port_clock_gate_props u_props (.aclk, .aresetn, .clk_en, .s_axi_awready,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .power_mode, .port_access, .port_answer,
    .port_clock_on, .port_disable);

/* sim/port_partner.sv */
// Model of the gated port blocks and of the power-mode controller.
// Assumes its tasks are called right after a rising aclk edge.
`timescale 1ns/10ps
module port_partner (
    input wire logic aclk,
    input wire port_gate_pkg::port_answer_type port_answer,
    output port_gate_pkg::power_mode_type power_mode,
    output port_gate_pkg::port_access_type port_access
);
    initial begin
        power_mode = port_gate_pkg::MODE_RUN;
        port_access = '0;
    end
    task automatic set_mode(input port_gate_pkg::power_mode_type m);
        power_mode <= m;
    endtask
    // Idle lines carry the inverse of the last request, so a stale value never passes.
    task automatic access(input logic w, input logic [2:0] p,
                          output port_gate_pkg::port_answer_type a);
        port_access <= '{valid: 1'h1, write: w, port: p};
        @(posedge aclk);
        port_access <= '{valid: 1'h0, write: ~w, port: ~p};
        @(posedge aclk);
        a = port_answer;
    endtask
endmodule

/* verilog/gate_select.sv */
// Chooses the active port clock enable set from the power mode.
// Assumes the power mode input is stable for at least a cycle.
`timescale 1ns/10ps
module gate_select (
    input wire port_gate_pkg::power_mode_type mode,
    input wire logic auto_sleep_gate_select,
    input wire logic [7:0] run_port_clock_enable,
    input wire logic [7:0] sleep_port_clock_enable,
    input wire logic [7:0] deep_sleep_port_clock_enable,
    output logic [7:0] port_enable
);

    always_comb begin
        port_enable = run_port_clock_enable;
        if (auto_sleep_gate_select) begin
            unique case (mode)
                port_gate_pkg::MODE_RUN: port_enable = run_port_clock_enable;
                port_gate_pkg::MODE_SLEEP: port_enable = sleep_port_clock_enable;
                port_gate_pkg::MODE_DEEP_SLEEP: begin
                    port_enable = deep_sleep_port_clock_enable;
                end
                default: port_enable = run_port_clock_enable;
            endcase
        end
    end

endmodule

/* verilog/port_clock_gate.sv */
// Port clock gating control with an AXI4-Lite register slave.
// Assumes aclk at 200 MHz, synchronous active-low reset, and that the
// power-mode controller drives power_mode synchronous to aclk.
//
// Behaviour
// - One enable per port, bits 7:0, port A at bit 0, set means clocked.
// - A clear enable stops the port clock and holds the port disabled.
// - Any access to a gated port while clk_en is high answers with a bus fault.
// - Deep-sleep enables reset to zero, all ports unclocked.
// - Run, sleep and deep-sleep enable sets apply in their own modes.
// - Sleep and deep-sleep enable sets apply only with automatic sleep gating selected.
// - Bits 31:8 read zero and ignore writes.
// - Deep-sleep enable register decodes at offset 0x128.
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module port_clock_gate (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire port_gate_pkg::power_mode_type power_mode,
    input wire port_gate_pkg::port_access_type port_access,
    output port_gate_pkg::port_answer_type port_answer,
    output logic [7:0] port_clock_on,
    output logic [7:0] port_disable,
    output logic irq
);

    // ==========================================================
    // Registers
    logic [31:0] run_clock_config_q;
    logic [7:0] run_port_clock_enable_q;
    logic [7:0] sleep_port_clock_enable_q;
    logic [7:0] deep_sleep_port_clock_enable_q;
    logic [1:0] irq_status_q;
    logic [1:0] irq_mask_q;
    port_gate_pkg::power_mode_type mode_q;
    logic [7:0] port_clock_on_q;
    port_gate_pkg::port_answer_type port_answer_q;

    // Write channel capture; address and data may arrive in either order.
    logic aw_held_q;
    logic w_held_q;
    logic [11:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    logic [7:0] port_enable;
    port_gate_pkg::port_answer_type answer_d;
    logic wr_fire;
    logic [1:0] irq_set;
    logic [1:0] irq_clear;

    // Merges byte lanes of a write into an old register value.
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
                                                input logic [31:0] new_val,
                                                input logic [3:0] strb);
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Byte offset of the aligned word that an address falls in.
    function automatic logic [11:0] word_offset(input logic [11:0] addr);
        return {addr[11:2], 2'b00};
    endfunction

    // Only the listed word offsets answer OKAY; the rest answer SLVERR.
    function automatic logic addr_mapped(input logic [11:0] addr);
        logic [11:0] word;
        word = word_offset(addr);
        return word == port_gate_pkg::RUN_CLOCK_CONFIG_OFF
            || word == port_gate_pkg::RUN_PORT_CLOCK_ENABLE_OFF
            || word == port_gate_pkg::SLEEP_PORT_CLOCK_ENABLE_OFF
            || word == port_gate_pkg::DEEP_SLEEP_PORT_CLOCK_ENABLE_OFF
            || word == port_gate_pkg::IRQ_STATUS_OFF
            || word == port_gate_pkg::IRQ_MASK_OFF
            || word == port_gate_pkg::POWER_STATE_OFF;
    endfunction

    // ==========================================================
    // Gating selection and access checking
    gate_select u_gate_select (
        .mode(mode_q),
        .auto_sleep_gate_select(run_clock_config_q[port_gate_pkg::AUTO_SLEEP_GATE_SELECT_BIT]),
        .run_port_clock_enable(run_port_clock_enable_q),
        .sleep_port_clock_enable(sleep_port_clock_enable_q),
        .deep_sleep_port_clock_enable(deep_sleep_port_clock_enable_q),
        .port_enable(port_enable)
    );

    port_fault_check u_port_fault_check (
        .access(port_access),
        .port_enable(port_clock_on_q),
        .answer(answer_d)
    );

    // ==========================================================
    // AXI write path
    // Readies drop while clk_en is low, so that no handshake completes against
    // frozen state; the master simply waits out the stall.
    assign s_axi_awready = clk_en && !aw_held_q && !bvalid_q;
    assign s_axi_wready = clk_en && !w_held_q && !bvalid_q;
    assign wr_fire = aw_held_q && w_held_q && !bvalid_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= 12'h000;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else if (clk_en) begin
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= port_gate_pkg::RESP_OKAY;
        end else if (clk_en) begin
            if (wr_fire) begin
                bvalid_q <= 1'b1;
                bresp_q <= addr_mapped(aw_addr_q) ? port_gate_pkg::RESP_OKAY
                                                  : port_gate_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Register writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_clock_config_q <= port_gate_pkg::RUN_CLOCK_CONFIG_RESET;
            run_port_clock_enable_q <= port_gate_pkg::PORT_ENABLE_RESET;
            sleep_port_clock_enable_q <= port_gate_pkg::PORT_ENABLE_RESET;
            deep_sleep_port_clock_enable_q <= port_gate_pkg::PORT_ENABLE_RESET;
            irq_mask_q <= port_gate_pkg::IRQ_RESET;
        end else if (clk_en && wr_fire) begin
            unique case (word_offset(aw_addr_q))
                port_gate_pkg::RUN_CLOCK_CONFIG_OFF:
                    run_clock_config_q <= merge_bytes(run_clock_config_q, w_data_q, w_strb_q);
                port_gate_pkg::RUN_PORT_CLOCK_ENABLE_OFF:
                    if (w_strb_q[0]) run_port_clock_enable_q <= w_data_q[7:0];
                port_gate_pkg::SLEEP_PORT_CLOCK_ENABLE_OFF:
                    if (w_strb_q[0]) sleep_port_clock_enable_q <= w_data_q[7:0];
                // Upper bits of the write are dropped.
                port_gate_pkg::DEEP_SLEEP_PORT_CLOCK_ENABLE_OFF:
                    if (w_strb_q[0]) deep_sleep_port_clock_enable_q <= w_data_q[7:0];
                port_gate_pkg::IRQ_MASK_OFF:
                    if (w_strb_q[0]) irq_mask_q <= w_data_q[1:0];
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // Interrupt status: set wins over a write-one clear.
    // Events are gathered by bit position so the status layout lives in one place.
    always_comb begin
        irq_set = 2'b00;
        irq_set[port_gate_pkg::IRQ_FAULT_BIT] = answer_d.fault;
        irq_set[port_gate_pkg::IRQ_MODE_BIT] = power_mode != mode_q;
    end

    // Only the low byte lane carries status bits, so only it can clear them.
    assign irq_clear = (wr_fire && w_strb_q[0]
                        && word_offset(aw_addr_q) == port_gate_pkg::IRQ_STATUS_OFF)
                       ? w_data_q[1:0] : 2'b00;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status_q <= port_gate_pkg::IRQ_RESET;
        end else if (clk_en) begin
            irq_status_q <= (irq_status_q & ~irq_clear) | irq_set;
        end
    end

    assign irq = |(irq_status_q & irq_mask_q);

    // ==========================================================
    // Power mode tracking, port clock gates and access answers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_q <= port_gate_pkg::MODE_RUN;
        end else if (clk_en) begin
            mode_q <= power_mode;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_clock_on_q <= port_gate_pkg::PORT_ENABLE_RESET;
        end else if (clk_en) begin
            port_clock_on_q <= port_enable;
        end
    end

    // The gate enables are registered so each port's clock gate sees a
    // glitch-free level; a port's own gating cell does the actual stopping.
    assign port_clock_on = port_clock_on_q;
    assign port_disable = ~port_clock_on_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_answer_q <= '0;
        end else if (clk_en) begin
            port_answer_q <= answer_d;
        end
    end

    assign port_answer = port_answer_q;

    // ==========================================================
    // AXI read path
    assign s_axi_arready = clk_en && !rvalid_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= port_gate_pkg::RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_arvalid && !rvalid_q) begin
                rvalid_q <= 1'b1;
                rresp_q <= addr_mapped(s_axi_araddr) ? port_gate_pkg::RESP_OKAY
                                                     : port_gate_pkg::RESP_SLVERR;
                unique case (word_offset(s_axi_araddr))
                    port_gate_pkg::RUN_CLOCK_CONFIG_OFF: rdata_q <= run_clock_config_q;
                    port_gate_pkg::RUN_PORT_CLOCK_ENABLE_OFF:
                        rdata_q <= {24'h000000, run_port_clock_enable_q};
                    port_gate_pkg::SLEEP_PORT_CLOCK_ENABLE_OFF:
                        rdata_q <= {24'h000000, sleep_port_clock_enable_q};
                    port_gate_pkg::DEEP_SLEEP_PORT_CLOCK_ENABLE_OFF:
                        rdata_q <= {24'h000000, deep_sleep_port_clock_enable_q};
                    port_gate_pkg::IRQ_STATUS_OFF: rdata_q <= {30'h0, irq_status_q};
                    port_gate_pkg::IRQ_MASK_OFF: rdata_q <= {30'h0, irq_mask_q};
                    port_gate_pkg::POWER_STATE_OFF:
                        rdata_q <= {14'h0, mode_q, 8'h00, port_clock_on_q};
                    default: rdata_q <= 32'h0000_0000;
                endcase
            end else if (s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

endmodule

/* verilog/port_fault_check.sv */
// Answers an access aimed at a port: a gated port yields a bus fault.
// Assumes the access request is a single-cycle descriptor.
`timescale 1ns/10ps
module port_fault_check (
    input wire port_gate_pkg::port_access_type access,
    input wire logic [7:0] port_enable,
    output port_gate_pkg::port_answer_type answer
);

    always_comb begin
        answer.fault = access.valid && !port_enable[access.port];
        answer.resp = answer.fault ? port_gate_pkg::RESP_SLVERR : port_gate_pkg::RESP_OKAY;
    end

endmodule

/* verilog/port_gate_pkg.sv */
// Shared constants and types for the port clock gating block.
// Assumes a 32-bit AXI4-Lite register bus and a single 200 MHz clock.
package port_gate_pkg;

    // ==========================================================
    // Sizes
    localparam int unsigned NUM_PORTS = 8;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;

    // ==========================================================
    // Register map (byte offsets from the system control base)
    localparam logic [31:0] SYSCTL_BASE = 32'h400f_e000;
    localparam logic [11:0] RUN_CLOCK_CONFIG_OFF = 12'h060;
    localparam logic [11:0] RUN_PORT_CLOCK_ENABLE_OFF = 12'h108;
    localparam logic [11:0] SLEEP_PORT_CLOCK_ENABLE_OFF = 12'h118;
    localparam logic [11:0] DEEP_SLEEP_PORT_CLOCK_ENABLE_OFF = 12'h128;
    localparam logic [11:0] IRQ_STATUS_OFF = 12'h200;
    localparam logic [11:0] IRQ_MASK_OFF = 12'h204;
    localparam logic [11:0] POWER_STATE_OFF = 12'h208;

    // ==========================================================
    // Field positions and reset values
    localparam int unsigned AUTO_SLEEP_GATE_SELECT_BIT = 27;
    localparam logic [7:0] PORT_ENABLE_RESET = 8'h00;
    localparam logic [31:0] RUN_CLOCK_CONFIG_RESET = 32'h0000_0000;
    localparam int unsigned IRQ_FAULT_BIT = 0;
    localparam int unsigned IRQ_MODE_BIT = 1;
    localparam logic [1:0] IRQ_RESET = 2'h0;

    // ==========================================================
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        MODE_RUN,
        MODE_SLEEP,
        MODE_DEEP_SLEEP
    } power_mode_type;

    typedef struct packed {
        logic valid;
        logic write;
        logic [2:0] port;
    } port_access_type;

    typedef struct packed {
        logic fault;
        logic [1:0] resp;
    } port_answer_type;

endpackage
